/* bench/rx_data_interface_fifo_tb_top.sv */
// Self-checking bench for the receive data interface and FIFO
`timescale 1ns/1ps
module rx_data_interface_fifo_tb_top;
    import rx_fifo_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = '0;
    logic [15:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    rx_chain_type rx = '0;
    irq_src_type irq = '0;
    logic sck, cs_n, sel, sdo, dec, pstb, chip, cstb, mf, raw, blk, tmo, wdc, fden, fsi, abrt, eomf;
    logic [259:0] q;
    logic gsp, wki;
    cycle_type cyc = '0;
    int err_count = 0;
    int n_compared = 0;
    rx_data_interface_fifo DUT (.i_clk_sys(clk), .i_srst(srst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_rx(rx),
        .i_cyc(cyc), .i_irq_src(irq), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
        .i_fifo_read_sel(sel), .o_fifo_sdo(sdo), .o_decoded_data(dec),
        .o_payload_strobe_out(pstb), .o_chip_stream_out(chip), .o_chip_strobe_out(cstb),
        .o_matched_filter_data(mf), .o_raw_slicer_data(raw), .o_framer_data_en(fden),
        .o_rx_chain_block(blk), .o_timeout_timer_disable(tmo),
        .o_wakeup_data_crit_disable(wdc), .o_goto_run_self_poll(gsp), .o_wakeup_irq(wki),
        .o_frame_sync_irq(fsi), .o_message_id_irq(), .o_eom_irq(),
        .o_external_abort_command(abrt), .o_ext_eom_found(eomf));
    rx_fifo_host_model u_host (.i_clk_sys(clk), .i_fifo_sdo(sdo), .o_spi_sck(sck),
        .o_spi_cs_n(cs_n), .o_fifo_read_sel(sel));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic pbit(input int i);
        return i[0] ^ i[2];
    endfunction : pbit
    function automatic logic [15:0] st(input int c, input logic [2:0] s, input logic o);
        return {3'h0, c[8:0], s, o};
    endfunction : st
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : check
    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(nm, e, rdata);
    endtask : rd_chk
    task automatic pulse_rx(input rx_chain_type m);
        @(posedge clk);
        rx <= rx | m;
        @(posedge clk);
        rx <= rx & ~m;
    endtask : pulse_rx
    task automatic send_bit(input logic b);
        @(posedge clk);
        rx.data_clk <= 1'b1;
        rx.data_bit <= b;
        @(posedge clk);
        rx.data_clk <= 1'b0;
    endtask : send_bit
    task automatic rx_frame(input int n);
        pulse_rx(9'h080);
        for (int i = 0; i < n; i++) send_bit(pbit(i));
        pulse_rx(9'h010);
    endtask : rx_frame
    task automatic fsync(input logic e);
        @(posedge clk);
        irq.frame_sync <= 1'b1;
        @(posedge clk);
        irq.frame_sync <= 1'b0;
        @(negedge clk);
        check("fsync_irq", e, fsi);
    endtask : fsync
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd_chk(ADDR_STATUS, st(0, 3'b001, 0), "status");
        rd_chk(ADDR_PTRS, 16'h0000, "ptrs");
        wr_reg(ADDR_CTRL, 16'h01fc);
        rd_chk(ADDR_CTRL, 16'h01fc, "ctrl");
        rd_chk(8'h10, 16'h0000, "unmapped");
        wr_reg(ADDR_CTRL, 16'h0000);
        rx_frame(10);
        send_bit(1'b1);
        rd_chk(ADDR_STATUS, st(10, 3'b001, 0), "count");
        u_host.read_bits(10, q);
        for (int i = 0; i < 10; i++) check("sdo", pbit(i), q[i]);
        wr_reg(ADDR_PTRS, 16'hffff);
        u_host.read_bits(1, q);
        check("sdo_empty", 1'b1, q[0]);
        rd_chk(ADDR_PTRS, 16'h0a0a, "ptrs");
        wr_reg(ADDR_CTRL, 16'h0040);
        rx_frame(3);
        pulse_rx(9'h080);
        rd_chk(ADDR_STATUS, st(3, 3'b100, 0), "lock");
        check("block", 1'b1, blk);
        u_host.read_bits(3, q);
        check("lock_data", 3'b010, q[2:0]);
        rd_chk(ADDR_STATUS, st(0, 3'b001, 0), "unlock_read");
        rx_frame(2);
        wr_reg(ADDR_CTRL, 16'h0000);
        rd_chk(ADDR_STATUS, st(2, 3'b001, 0), "unlock_bit");
        rx_frame(258);
        rd_chk(ADDR_STATUS, st(256, 3'b001, 1), "overflow");
        rd_chk(ADDR_PTRS, 16'h0d11, "wrap");
        pulse_rx(9'h080);
        rd_chk(ADDR_STATUS, st(0, 3'b010, 0), "reinit");
        rd_chk(ADDR_PTRS, 16'h0000, "reinit_ptrs");
        @(posedge clk);
        rx <= 9'h100;
        for (int v = 0; v < 2; v++) begin
            wr_reg(ADDR_CTRL, 16'h0001 | 16'(v << 3));
            for (int i = 0; i < 4; i++) begin
                send_bit(pbit(i));
                repeat (8) @(posedge clk);
                @(negedge clk);
                check("dec", pbit(i), dec);
                if (i > 1) check("pstb_on", v == 0, pstb);
                repeat (15) @(posedge clk);
                @(negedge clk);
                if (i > 1) check("pstb_off", v != 0, pstb);
                repeat (7) @(posedge clk);
            end
        end
        @(posedge clk);
        rx <= 9'h107;
        for (int m = 2; m < 5; m++) begin
            wr_reg(ADDR_CTRL, 16'(m));
            repeat (3) @(posedge clk);
            @(negedge clk);
            check("pins", 16'h0004 >> (m - 2), {chip, mf, raw});
        end
        @(posedge clk);
        rx.active <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("idle_pins", 16'h0000, {dec, pstb, chip, cstb, mf, raw});
        fsync(1'b1);
        wr_reg(ADDR_CTRL, 16'h0100);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("ext_ctl", 3'b110, {tmo, wdc, fden});
        fsync(1'b0);
        wr_reg(ADDR_CMD, 16'h0001);
        @(negedge clk);
        check("abort", 2'b10, {abrt, eomf});
        wr_reg(ADDR_CMD, 16'h0002);
        cyc <= 5'h1e;
        @(negedge clk);
        check("eom_found", 2'b01, {abrt, eomf});
        @(posedge clk);
        cyc <= 5'h00;
        @(negedge clk);
        check("wake", 2'b11, {gsp, wki});
        give_verdict();
    end
endmodule : rx_data_interface_fifo_tb_top

/* bench/rx_fifo_host_model.sv */
// Host model reading the receive FIFO over the serial lines
`timescale 1ns/1ps
module rx_fifo_host_model (
    // Clock and data
    input wire logic i_clk_sys,
    input wire logic i_fifo_sdo,
    // Serial lines
    output logic o_spi_sck,
    output logic o_spi_cs_n,
    output logic o_fifo_read_sel
);
    initial begin
        o_spi_sck = 1'b1;
        o_spi_cs_n = 1'b1;
        o_fifo_read_sel = 1'b0;
    end
    task automatic read_bits(input int n, output logic [259:0] q);
        q = '0;
        @(posedge i_clk_sys);
        o_spi_cs_n <= 1'b0;
        o_fifo_read_sel <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk_sys);
            o_spi_sck <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
            o_spi_sck <= 1'b1;
            repeat (2) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            q[i] = i_fifo_sdo;
            @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys);
        o_spi_cs_n <= 1'b1;
        o_fifo_read_sel <= 1'b0;
    endtask : read_bits
endmodule : rx_fifo_host_model

/* design/rx_data_interface_fifo.sv */
// Receive data path: packet FIFO, transparent outputs, strobes and FIFO lock
//
// Operation
// [RULE_01] FIFO packet mode stores payload only and delivers it serially.
// [RULE_02] Transparent payload mode shows each payload bit with its strobe.
// [RULE_03] Decoded data and chip data outputs are low while receiver inactive.
// [RULE_04] Payload strobe starts T_BIT/16 after bit, lasts T_BIT/2, polarity selectable.
// [RULE_05] Chip mode drives chip stream out, optionally with estimated chip strobe.
// [RULE_06] Chip strobe starts T_CHIP/8 after chip, lasts T_CHIP/2, polarity selectable.
// [RULE_07] Matched filter mode outputs sign of two-chip matched filter.
// [RULE_08] Raw slicer mode outputs one-chip matched filter result.
// [RULE_09] RSSI inside window in self polling moves to run mode, may interrupt.
// [RULE_10] Host aborts bad data or reports end of message by command.
// [RULE_11] External processing blocks framer data, frame interrupts, timeouts, data wake-up.
// [RULE_12] Host disables timeouts and places external set last in on time.
// [RULE_13] FIFO used only in packet FIFO mode, 256 bits, bit addressable.
// [RULE_14] Host reads long packets early enough, counting extra leading bit.
// [RULE_15] Writing begins at frame start; write pointer advances per data clock.
// [RULE_16] Read pointer advances per bit read by the serial controller.
// [RULE_17] Both pointers wrap from 255 to zero.
// [RULE_18] Writing stops at end of message or sync loss.
// [RULE_19] With lock enabled, FIFO locks at end of message, blocking receive chain.
// [RULE_20] Lock released on full readout, lock bit cleared, or init at cycle start.
// [RULE_21] Write overtaking read sets overflow; frame start clears it and reinitialises.
// [RULE_22] Reset clears pointers, overflow and lock, outputs low.
// [RULE_23] Chip clock estimate only for constant chip rate, tightened by run-in.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps

module rx_data_interface_fifo #(
    parameter int DEPTH = 256,
    parameter int PERIOD_W = 16
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Register port
    input wire logic [rx_fifo_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [rx_fifo_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [rx_fifo_pkg::DATA_W-1:0] o_reg_rdata,
    // Receive chain and cycle controller
    input wire rx_fifo_pkg::rx_chain_type i_rx,
    input wire rx_fifo_pkg::cycle_type i_cyc,
    input wire rx_fifo_pkg::irq_src_type i_irq_src,
    // Serial FIFO readout
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_fifo_read_sel,
    output logic o_fifo_sdo,
    // Port pin data
    output logic o_decoded_data,
    output logic o_payload_strobe_out,
    output logic o_chip_stream_out,
    output logic o_chip_strobe_out,
    output logic o_matched_filter_data,
    output logic o_raw_slicer_data,
    // Control toward receive chain and cycle controller
    output logic o_framer_data_en,
    output logic o_rx_chain_block,
    output logic o_timeout_timer_disable,
    output logic o_wakeup_data_crit_disable,
    output logic o_goto_run_self_poll,
    output logic o_wakeup_irq,
    output logic o_frame_sync_irq,
    output logic o_message_id_irq,
    output logic o_eom_irq,
    output logic o_external_abort_command,
    output logic o_ext_eom_found
);
    import rx_fifo_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
    localparam logic [PERIOD_W-1:0] PERIOD_SAT = '1;

    ctrl_type ctrl_ff;
    fifo_state_type state_ff;
    fifo_state_type nxt_state;
    logic mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] count_ff;
    logic overflow_ff;
    logic sck_meta_ff;
    logic sck_sync_ff;
    logic sck_prev_ff;
    logic cs_n_meta_ff;
    logic cs_n_sync_ff;
    logic sck_fall;
    logic wr_evt;
    logic rd_evt;
    logic init_fifo;
    logic frame_ok;
    logic lock_release;
    logic chip_prev_ff;
    logic [1:0] ch_evt;
    logic [1:0] ch_free;
    logic [1:0] ch_win;
    logic mode_pof;
    logic mode_potp;
    logic mode_cds;

    assign mode_pof = (ctrl_ff.mode == MODE_FIFO_PACKET);
    assign mode_potp = (ctrl_ff.mode == MODE_TRANSPARENT_PAYLOAD);
    assign mode_cds = (ctrl_ff.mode == MODE_CHIP_DATA_STROBE);

    // Register writes
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ctrl_ff <= CTRL_RESET;
        end else if (i_reg_wr && (i_reg_addr == ADDR_CTRL)) begin
            ctrl_ff <= ctrl_type'(i_reg_wdata[$bits(ctrl_type)-1:0]);
        end
    end

    // [RULE_10] Host command pulses
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_external_abort_command <= 1'b0;
            o_ext_eom_found <= 1'b0;
        end else begin
            o_external_abort_command <= i_reg_wr && (i_reg_addr == ADDR_CMD)
                && i_reg_wdata[CMD_ABORT_BIT];
            o_ext_eom_found <= i_reg_wr && (i_reg_addr == ADDR_CMD)
                && i_reg_wdata[CMD_EOM_FOUND_BIT];
        end
    end

    // Register reads, data one cycle after strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_reg_rdata <= '0;
        end else if (!i_reg_rd) begin
            o_reg_rdata <= '0;
        end else if (i_reg_addr == ADDR_CTRL) begin
            o_reg_rdata <= DATA_W'(ctrl_ff);
        end else if (i_reg_addr == ADDR_STATUS) begin
            o_reg_rdata <= DATA_W'({count_ff, state_ff, overflow_ff});
        end else if (i_reg_addr == ADDR_PTRS) begin
            o_reg_rdata <= DATA_W'({rd_ptr_ff, wr_ptr_ff});
        end else begin
            o_reg_rdata <= '0;
        end
    end

    // Serial clock and select synchronisers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sck_meta_ff <= 1'b0;
            sck_sync_ff <= 1'b0;
            sck_prev_ff <= 1'b0;
            cs_n_meta_ff <= 1'b1;
            cs_n_sync_ff <= 1'b1;
        end else begin
            sck_meta_ff <= i_spi_sck;
            sck_sync_ff <= sck_meta_ff;
            sck_prev_ff <= sck_sync_ff;
            cs_n_meta_ff <= i_spi_cs_n;
            cs_n_sync_ff <= cs_n_meta_ff;
        end
    end

    assign sck_fall = sck_prev_ff && !sck_sync_ff;
    // [RULE_11] Framer input closed under external processing
    assign frame_ok = i_rx.frame_start && !ctrl_ff.external_processing_enable;
    // [RULE_13] Store only in packet FIFO mode
    assign wr_evt = (state_ff == ST_WRITE) && i_rx.data_clk && mode_pof;
    // [RULE_16] One read per falling serial clock
    assign rd_evt = sck_fall && !cs_n_sync_ff && i_fifo_read_sel && (count_ff != '0);
    // [RULE_21] Frame start after overflow, init at cycle start
    assign init_fifo = (frame_ok && overflow_ff && (state_ff != ST_LOCK))
        || (ctrl_ff.init_at_cycle_start && (i_cyc.enter_run_slave || o_goto_run_self_poll));
    // [RULE_20] Lock release conditions
    assign lock_release = (count_ff == '0) || !ctrl_ff.fifo_lock_enable || init_fifo;

    // FIFO state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                // [RULE_15] Writing starts at frame start
                if (frame_ok) begin
                    nxt_state = ST_WRITE;
                end
            end
            ST_WRITE: begin
                // [RULE_18] Stop on sync loss or end
                if (i_rx.sync_lost) begin
                    nxt_state = ST_IDLE;
                end else if (i_rx.end_of_message) begin
                    // [RULE_19] Lock at end of message
                    nxt_state = ctrl_ff.fifo_lock_enable ? ST_LOCK : ST_IDLE;
                end
            end
            ST_LOCK: begin
                if (lock_release) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // [RULE_22] State and lock cleared on reset
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
            o_rx_chain_block <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            o_rx_chain_block <= (nxt_state == ST_LOCK);
        end
    end

    // [RULE_13] Bit addressable store
    always_ff @(posedge i_clk_sys) begin
        if (wr_evt) begin
            mem[wr_ptr_ff] <= i_rx.data_bit;
        end
    end

    // [RULE_17] Pointers wrap at the top
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || init_fifo) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (wr_evt) begin
                wr_ptr_ff <= (wr_ptr_ff == PTR_MAX) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (rd_evt) begin
                rd_ptr_ff <= (rd_ptr_ff == PTR_MAX) ? '0 : rd_ptr_ff + 1'b1;
            end
        end
    end

    // Fill level, saturates when write overtakes read
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || init_fifo) begin
            count_ff <= '0;
        end else if (wr_evt && !rd_evt && (count_ff != COUNT_FULL)) begin
            count_ff <= count_ff + 1'b1;
        end else if (rd_evt && !wr_evt) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    // [RULE_21] Overflow flag
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || init_fifo) begin
            overflow_ff <= 1'b0;
        end else if (wr_evt && !rd_evt && (count_ff == COUNT_FULL)) begin
            overflow_ff <= 1'b1;
        end
    end

    // [RULE_01] Serial payload delivery
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_fifo_sdo <= 1'b0;
        end else if (rd_evt) begin
            o_fifo_sdo <= mem[rd_ptr_ff];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            chip_prev_ff <= 1'b0;
        end else begin
            chip_prev_ff <= i_rx.chip_bit;
        end
    end

    // Channel 0 payload bits, channel 1 chips
    assign ch_evt[0] = wr_evt || ((state_ff == ST_WRITE) && i_rx.data_clk && mode_potp);
    assign ch_evt[1] = i_rx.active && (i_rx.chip_bit != chip_prev_ff);
    assign ch_free[0] = 1'b0;
    assign ch_free[1] = 1'b1;

    // Period estimate and strobe window per channel
    for (genvar ch = 0; ch < 2; ch++) begin : g_strobe
        localparam int DSH = (ch == 0) ? BIT_STROBE_DELAY_SHIFT : CHIP_STROBE_DELAY_SHIFT;
        logic [PERIOD_W-1:0] gap_ff;
        logic [PERIOD_W-1:0] per_ff;
        logic [PERIOD_W-1:0] phase_ff;
        logic [PERIOD_W-1:0] start;

        assign start = per_ff >> DSH;
        assign ch_win[ch] = (per_ff != '0) && (phase_ff >= start)
            && (phase_ff < start + (per_ff >> STROBE_LEN_SHIFT));

        // [RULE_23] Bit period takes every interval, chip period only those under 1.5 periods; alternating run-in tightens it
        always_ff @(posedge i_clk_sys) begin
            if (i_srst) begin
                per_ff <= '0;
            end else if (ch_evt[ch] && (gap_ff != PERIOD_SAT) && (!ch_free[ch]
                    || (per_ff == '0) || (gap_ff < per_ff + (per_ff >> 1)))) begin
                per_ff <= gap_ff + 1'b1;
            end
        end

        always_ff @(posedge i_clk_sys) begin
            if (i_srst || ch_evt[ch]) begin
                gap_ff <= '0;
            end else if (gap_ff != PERIOD_SAT) begin
                gap_ff <= gap_ff + 1'b1;
            end
        end

        // Phase restarts at each real boundary, and on the chip channel also at each predicted one
        always_ff @(posedge i_clk_sys) begin
            if (i_srst || ch_evt[ch]) begin
                phase_ff <= '0;
            end else if (ch_free[ch] && (per_ff != '0) && (phase_ff == per_ff - 1'b1)) begin
                phase_ff <= '0;
            end else if (phase_ff != PERIOD_SAT) begin
                phase_ff <= phase_ff + 1'b1;
            end
        end
    end

    // [RULE_03] Port pin outputs, low while inactive
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !i_rx.active) begin
            o_decoded_data <= 1'b0;
            o_payload_strobe_out <= 1'b0;
            o_chip_stream_out <= 1'b0;
            o_chip_strobe_out <= 1'b0;
            o_matched_filter_data <= 1'b0;
            o_raw_slicer_data <= 1'b0;
        end else begin
            // [RULE_02] Payload bit on decoded data
            if (ch_evt[0] && mode_potp) begin
                o_decoded_data <= i_rx.data_bit;
            end
            // [RULE_04] Payload strobe window
            o_payload_strobe_out <= mode_potp && (ch_win[0] ^ ctrl_ff.payload_strobe_inv);
            // [RULE_05] Chip stream passed through
            o_chip_stream_out <= mode_cds && i_rx.chip_bit;
            // [RULE_06] Chip strobe window
            o_chip_strobe_out <= mode_cds && ctrl_ff.chip_strobe_en
                && (ch_win[1] ^ ctrl_ff.chip_strobe_inv);
            // [RULE_07] Two-chip filter sign
            o_matched_filter_data <= (ctrl_ff.mode == MODE_MATCHED_FILTER) && i_rx.mf2_sign;
            // [RULE_08] One-chip filter result
            o_raw_slicer_data <= (ctrl_ff.mode == MODE_RAW_SLICER) && i_rx.mf1_out;
        end
    end

    // [RULE_11] External processing suppression
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_framer_data_en <= 1'b0;
            o_timeout_timer_disable <= 1'b0;
            o_wakeup_data_crit_disable <= 1'b0;
            o_frame_sync_irq <= 1'b0;
            o_message_id_irq <= 1'b0;
            o_eom_irq <= 1'b0;
        end else begin
            o_framer_data_en <= !ctrl_ff.external_processing_enable && (nxt_state != ST_LOCK);
            o_timeout_timer_disable <= ctrl_ff.external_processing_enable;
            o_wakeup_data_crit_disable <= ctrl_ff.external_processing_enable;
            o_frame_sync_irq <= i_irq_src.frame_sync && !ctrl_ff.external_processing_enable;
            o_message_id_irq <= i_irq_src.message_id && !ctrl_ff.external_processing_enable;
            o_eom_irq <= i_irq_src.end_of_message && !ctrl_ff.external_processing_enable;
        end
    end

    // [RULE_09] Wake-up on signal strength
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_goto_run_self_poll <= 1'b0;
            o_wakeup_irq <= 1'b0;
        end else begin
            o_goto_run_self_poll <= i_cyc.self_polling && i_cyc.rssi_sample
                && i_cyc.rssi_in_window;
            o_wakeup_irq <= i_cyc.self_polling && i_cyc.rssi_sample
                && i_cyc.rssi_in_window && i_cyc.wakeup_irq_en;
        end
    end

    property p_wr_step;
        @(posedge i_clk_sys) disable iff (i_srst)
        (wr_evt && !init_fifo) |=>
            (wr_ptr_ff == (($past(wr_ptr_ff) == PTR_MAX) ? '0 : $past(wr_ptr_ff) + 1'b1));
    endproperty
    a_wr_step: assert property (p_wr_step) else $error("write pointer step wrong"); // [RULE_15]

    property p_rd_step;
        @(posedge i_clk_sys) disable iff (i_srst)
        (rd_evt && !init_fifo) |=> (rd_ptr_ff != $past(rd_ptr_ff)) && !$stable(count_ff | {
            (PTR_W + 1){wr_evt}});
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read pointer did not advance"); // [RULE_16]

    property p_wrap;
        @(posedge i_clk_sys) disable iff (i_srst)
        (wr_evt && !init_fifo && (wr_ptr_ff == PTR_MAX)) |=> (wr_ptr_ff == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("write pointer did not wrap"); // [RULE_17]

    property p_stop;
        @(posedge i_clk_sys) disable iff (i_srst)
        ((state_ff == ST_WRITE) && i_rx.sync_lost) ##1 (!frame_ok && !init_fifo)
            |=> $stable(wr_ptr_ff);
    endproperty
    a_stop: assert property (p_stop) else $error("write continued after sync loss"); // [RULE_18]

    property p_lock;
        @(posedge i_clk_sys) disable iff (i_srst)
        ((state_ff == ST_WRITE) && i_rx.end_of_message && !i_rx.sync_lost
            && ctrl_ff.fifo_lock_enable) |=> o_rx_chain_block && !o_framer_data_en[*1];
    endproperty
    a_lock: assert property (p_lock) else $error("lock not taken at end of message"); // [RULE_19]

    property p_release;
        @(posedge i_clk_sys) disable iff (i_srst)
        ((state_ff == ST_LOCK) && !ctrl_ff.fifo_lock_enable) |=> !o_rx_chain_block;
    endproperty
    a_release: assert property (p_release) else $error("lock held after lock bit cleared"); // [RULE_20]

    property p_overflow;
        @(posedge i_clk_sys) disable iff (i_srst)
        (wr_evt && !rd_evt && !init_fifo && (count_ff == COUNT_FULL)) |=> overflow_ff;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // [RULE_21]

    property p_reset;
        @(posedge i_clk_sys)
        i_srst |=> (wr_ptr_ff == '0) && (rd_ptr_ff == '0) && !overflow_ff && !o_rx_chain_block
            && !o_decoded_data && !o_chip_strobe_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong"); // [RULE_22]

    property p_inactive;
        @(posedge i_clk_sys) disable iff (i_srst)
        !i_rx.active |=> !o_decoded_data && !o_chip_stream_out;
    endproperty
    a_inactive: assert property (p_inactive) else $error("data line high while inactive"); // [RULE_03]

    property p_chip_pass;
        @(posedge i_clk_sys) disable iff (i_srst)
        (i_rx.active && mode_cds) |=> (o_chip_stream_out == $past(i_rx.chip_bit));
    endproperty
    a_chip_pass: assert property (p_chip_pass) else $error("chip stream not passed"); // [RULE_05]

    property p_ext_block;
        @(posedge i_clk_sys) disable iff (i_srst)
        ctrl_ff.external_processing_enable |=> !o_frame_sync_irq && !o_eom_irq
            && !o_framer_data_en && o_timeout_timer_disable;
    endproperty
    a_ext_block: assert property (p_ext_block) else $error("frame events not suppressed"); // [RULE_11]

    property p_abort;
        @(posedge i_clk_sys) disable iff (i_srst)
        (i_reg_wr && (i_reg_addr == ADDR_CMD) && i_reg_wdata[CMD_ABORT_BIT])
            |=> o_external_abort_command ##1 !o_external_abort_command || $past(i_reg_wr);
    endproperty
    a_abort: assert property (p_abort) else $error("abort command not pulsed"); // [RULE_10]

endmodule : rx_data_interface_fifo

/* include/rx_fifo_pkg.sv */
// Constants, modes and carrier types for the receive data interface and FIFO
package rx_fifo_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PTRS = 8'h0c;

    // Command register bit positions
    localparam int CMD_ABORT_BIT = 0;
    localparam int CMD_EOM_FOUND_BIT = 1;

    // Strobe delay and length as right shifts of the measured period
    localparam int BIT_STROBE_DELAY_SHIFT = 4;
    localparam int CHIP_STROBE_DELAY_SHIFT = 3;
    localparam int STROBE_LEN_SHIFT = 1;

    typedef enum logic [2:0] {
        MODE_FIFO_PACKET = 3'h0,
        MODE_TRANSPARENT_PAYLOAD = 3'h1,
        MODE_CHIP_DATA_STROBE = 3'h2,
        MODE_MATCHED_FILTER = 3'h3,
        MODE_RAW_SLICER = 3'h4
    } rx_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_LOCK = 3'b100
    } fifo_state_type;

    typedef struct packed {
        logic external_processing_enable;
        logic init_at_cycle_start;
        logic fifo_lock_enable;
        logic chip_strobe_en;
        logic chip_strobe_inv;
        logic payload_strobe_inv;
        rx_mode_type mode;
    } ctrl_type;

    localparam ctrl_type CTRL_RESET = 9'h000;

    // Signals from the digital receive chain
    typedef struct packed {
        logic active;
        logic frame_start;
        logic data_clk;
        logic data_bit;
        logic end_of_message;
        logic sync_lost;
        logic chip_bit;
        logic mf2_sign;
        logic mf1_out;
    } rx_chain_type;

    // Signals from the cycle controller
    typedef struct packed {
        logic self_polling;
        logic rssi_sample;
        logic rssi_in_window;
        logic wakeup_irq_en;
        logic enter_run_slave;
    } cycle_type;

    // Interrupt events of the framer
    typedef struct packed {
        logic frame_sync;
        logic message_id;
        logic end_of_message;
    } irq_src_type;

endpackage : rx_fifo_pkg
